// >>> include/qtimer_map.svh
`ifndef QTIMER_MAP_SVH
`define QTIMER_MAP_SVH

`define QT_NUM_TIMERS 4
`define QT_CNT_W 32
`define QT_ADDR_W 8

// Per timer block: base = index * stride
`define QT_TMR_STRIDE 8'h10
`define QT_OFS_LOAD 8'h00
`define QT_OFS_VALUE 8'h04
`define QT_OFS_CTRL 8'h08
`define QT_OFS_IRQ_STATUS 8'h40
`define QT_OFS_IRQ_CLEAR 8'h44
`define QT_OFS_IRQ_ENABLE 8'h48

`define QT_CTRL_ENABLE_BIT 0
`define QT_CTRL_PERIODIC_BIT 1
`define QT_CTRL_PRESC_LSB 2
`define QT_CTRL_PRESC_MSB 3

`define QT_PRESC_DIV1 2'h0
`define QT_PRESC_DIV16 2'h1
`define QT_PRESC_DIV256 2'h2
`define QT_DIV16_LAST 8'h0f
`define QT_DIV256_LAST 8'hff

`define QT_LOAD_RST 32'h00000000
`define QT_CNT_RST 32'hffffffff
`define QT_CNT_WRAP 32'hffffffff
`define QT_CTRL_RST 4'h0

`define QT_RESP_OKAY 2'h0
`define QT_RESP_SLVERR 2'h2

`endif

// >>> include/qtimer_pkg.sv
package qtimer_pkg;

    typedef struct packed {
        logic [1:0] presc;
        logic periodic;
        logic enable;
    } ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_s;

endpackage

// >>> src/qtimer_channel.sv
`timescale 1ns/1ps
`default_nettype none
`include "qtimer_map.svh"

module qtimer_channel (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire qtimer_pkg::ctrl_s cfg_i,
    input wire logic [31:0] load_val_i,
    input wire logic load_wr_i,
    output logic [31:0] cnt_o,
    output logic [7:0] pre_o,
    output logic tick_o,
    output logic zero_o
);

    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic [7:0] pre_ff;
    logic [7:0] nxt_pre;
    logic tick;

    always_comb begin
        case (cfg_i.presc)
            `QT_PRESC_DIV1: tick = cfg_i.enable;
            `QT_PRESC_DIV16: tick = cfg_i.enable &&
                (pre_ff[3:0] == `QT_DIV16_LAST);
            `QT_PRESC_DIV256: tick = cfg_i.enable &&
                (pre_ff == `QT_DIV256_LAST);
            default: tick = 1'b0;
        endcase
    end

    always_comb begin
        nxt_pre = pre_ff;
        nxt_cnt = cnt_ff;
        if (load_wr_i) begin
            // Restart: new value and a fresh prescale phase
            nxt_pre = 8'h00;
            nxt_cnt = load_val_i;
        end else if (cfg_i.enable) begin
            nxt_pre = pre_ff + 8'h01;
            if (tick) begin
                if (cnt_ff != 32'h00000000) begin
                    nxt_cnt = cnt_ff - 32'h00000001;
                end else if (cfg_i.periodic) begin
                    nxt_cnt = load_val_i;
                end else begin
                    nxt_cnt = `QT_CNT_WRAP;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cnt_ff <= `QT_CNT_RST;
            pre_ff <= 8'h00;
        end else begin
            cnt_ff <= nxt_cnt;
            pre_ff <= nxt_pre;
        end
    end

    assign cnt_o = cnt_ff;
    assign pre_o = pre_ff;
    assign tick_o = tick;
    // Only a tick arrival at zero counts; a load write of zero does not
    assign zero_o = tick && !load_wr_i && (nxt_cnt == 32'h00000000);

endmodule
`default_nettype wire

// >>> src/qtimer_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "qtimer_map.svh"

module qtimer_axil_slave (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output qtimer_pkg::wr_req_s wr_o,
    output logic wr_en_o,
    input wire logic wr_err_i,
    output logic [7:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_err_i
);

    logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
    logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    qtimer_pkg::wr_req_s req_ff, nxt_req;
    logic do_wr, ar_hs;
    // Readies are kept in flops so every AXI output leaves straight from one
    logic awready_ff, wready_ff, arready_ff;

    assign do_wr = aw_have_ff && w_have_ff && !bvalid_ff;
    assign ar_hs = s_axi_arvalid && !rvalid_ff;

    always_comb begin
        nxt_aw_have = aw_have_ff;
        nxt_w_have = w_have_ff;
        nxt_req = req_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && !aw_have_ff) begin
            nxt_aw_have = 1'b1;
            nxt_req.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_ff) begin
            nxt_w_have = 1'b1;
            nxt_req.data = s_axi_wdata;
            nxt_req.strb = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_aw_have = 1'b0;
            nxt_w_have = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = wr_err_i ? `QT_RESP_SLVERR : `QT_RESP_OKAY;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (ar_hs) begin
            // Value sampled at the handshake; counting goes on untouched
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_data_i;
            nxt_rresp = rd_err_i ? `QT_RESP_SLVERR : `QT_RESP_OKAY;
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            req_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= 2'h0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            arready_ff <= 1'b1;
        end else begin
            awready_ff <= !nxt_aw_have;
            wready_ff <= !nxt_w_have;
            arready_ff <= !nxt_rvalid;
            aw_have_ff <= nxt_aw_have;
            w_have_ff <= nxt_w_have;
            req_ff <= nxt_req;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign wr_o = req_ff;
    assign wr_en_o = do_wr;
    assign rd_addr_o = s_axi_araddr;

endmodule
`default_nettype wire

// >>> src/quad_downcount_timer.sv
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "qtimer_map.svh"

module quad_downcount_timer (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] tmr_irq_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave

    qtimer_pkg::wr_req_s wr;
    logic wr_en, wr_err, rd_err;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;

    qtimer_axil_slave u_bus (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_o(wr),
        .wr_en_o(wr_en),
        .wr_err_i(wr_err),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_err_i(rd_err)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic [31:0] load_ff [4];
    logic [31:0] nxt_load [4];
    qtimer_pkg::ctrl_s ctrl_ff [4];
    qtimer_pkg::ctrl_s nxt_ctrl [4];
    logic [3:0] status_ff, nxt_status;
    logic [3:0] ien_ff, nxt_ien;
    logic [3:0] tmr_irq_ff, nxt_tmr_irq;
    logic irq_ff, nxt_irq;
    logic [3:0] load_wr, zero_evt, tick;
    logic [31:0] cnt [4];
    logic [7:0] pre [4];
    logic [31:0] wmask;
    logic clr_wr, ien_wr;

    // Byte strobes widened to a bit mask
    assign wmask = {{8{wr.strb[3]}}, {8{wr.strb[2]}},
                    {8{wr.strb[1]}}, {8{wr.strb[0]}}};
    assign clr_wr = wr_en && (wr.addr == `QT_OFS_IRQ_CLEAR);
    assign ien_wr = wr_en && (wr.addr == `QT_OFS_IRQ_ENABLE);
    // VALUE and STATUS are read-only; a write there answers with an error
    assign wr_err = !((wr.addr[7:6] == 2'h0 &&
                       (wr.addr[3:0] == `QT_OFS_LOAD ||
                        wr.addr[3:0] == `QT_OFS_CTRL)) ||
                      wr.addr == `QT_OFS_IRQ_CLEAR ||
                      wr.addr == `QT_OFS_IRQ_ENABLE);

    ////////////////////////////////////////////////////////////////////////
    // Timers

    genvar gi;
    generate
        for (gi = 0; gi < `QT_NUM_TIMERS; gi++) begin : g_tmr
            localparam logic [7:0] BASE = 8'(gi * 16);

            assign load_wr[gi] = wr_en &&
                (wr.addr == BASE + `QT_OFS_LOAD);

            always_comb begin
                nxt_load[gi] = load_ff[gi];
                nxt_ctrl[gi] = ctrl_ff[gi];
                if (load_wr[gi]) begin
                    nxt_load[gi] = (load_ff[gi] & ~wmask) |
                        (wr.data & wmask);
                end
                if (wr_en && wr.addr == BASE + `QT_OFS_CTRL &&
                    wr.strb[0]) begin
                    nxt_ctrl[gi] = qtimer_pkg::ctrl_s'(
                        wr.data[`QT_CTRL_PRESC_MSB:0]);
                end
            end

            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    load_ff[gi] <= `QT_LOAD_RST;
                    ctrl_ff[gi] <= `QT_CTRL_RST;
                end else begin
                    load_ff[gi] <= nxt_load[gi];
                    ctrl_ff[gi] <= nxt_ctrl[gi];
                end
            end

            // One private counter per timer, nothing shared between them
            qtimer_channel u_chan (
                .clk_i(clk_i),
                .sys_rst_i(sys_rst_i),
                .cfg_i(ctrl_ff[gi]),
                .load_val_i(nxt_load[gi]),
                .load_wr_i(load_wr[gi]),
                .cnt_o(cnt[gi]),
                .pre_o(pre[gi]),
                .tick_o(tick[gi]),
                .zero_o(zero_evt[gi])
            );

            AST_DEC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                tick[gi] && !load_wr[gi] && cnt[gi] != 32'h0 |=>
                cnt[gi] == $past(cnt[gi]) - 32'h1)
                else $error("count did not drop by one on a tick");
            AST_DIV1: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                ctrl_ff[gi].enable && ctrl_ff[gi].presc == `QT_PRESC_DIV1 |->
                tick[gi])
                else $error("undivided timer missed a tick");
            AST_DIV256: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                tick[gi] && ctrl_ff[gi].presc == `QT_PRESC_DIV256 |->
                pre[gi] == 8'hff ##1 !tick[gi])
                else $error("divide by 256 tick out of phase");
            AST_DIV16: assert property (
                @(posedge clk_i) disable iff (sys_rst_i)
                tick[gi] && ctrl_ff[gi].presc == `QT_PRESC_DIV16 |->
                pre[gi][3:0] == 4'hf)
                else $error("divide by 16 tick out of phase");
            // Code 3 is a parked prescaler: no ticks at all
            AST_PRESC_OFF: assert property (
                @(posedge clk_i) disable iff (sys_rst_i)
                ctrl_ff[gi].presc == 2'h3 |-> !tick[gi])
                else $error("parked prescaler produced a tick");
            AST_NO_LOAD_FLAG: assert property (
                @(posedge clk_i) disable iff (sys_rst_i)
                load_wr[gi] |-> !zero_evt[gi])
                else $error("load write raised a zero event");
            AST_WRAP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                tick[gi] && !load_wr[gi] && cnt[gi] == 32'h0 &&
                !ctrl_ff[gi].periodic |=> cnt[gi] == 32'hffffffff)
                else $error("free-running counter did not wrap");
            AST_RELOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                tick[gi] && !load_wr[gi] && cnt[gi] == 32'h0 &&
                ctrl_ff[gi].periodic |=> cnt[gi] == load_ff[gi])
                else $error("periodic counter did not reload");
            AST_RESTART: assert property (@(posedge clk_i)
                disable iff (sys_rst_i)
                load_wr[gi] |=> cnt[gi] == load_ff[gi] &&
                pre[gi] == 8'h00)
                else $error("load write did not restart the timer");
            AST_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
                !ctrl_ff[gi].enable && !load_wr[gi] |=>
                $stable(cnt[gi]))
                else $error("disabled timer changed its count");
            AST_ZERO_IRQ: assert property (@(posedge clk_i)
                disable iff (sys_rst_i)
                $changed(cnt[gi]) && cnt[gi] == 32'h0 &&
                !$past(load_wr[gi]) |-> status_ff[gi])
                else $error("arrival at zero raised no flag");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, clear and enable

    always_comb begin
        nxt_ien = ien_ff;
        if (ien_wr && wr.strb[0]) begin
            nxt_ien = wr.data[3:0];
        end
        // A zero crossing in the clearing cycle survives the clear
        nxt_status = status_ff;
        if (clr_wr && wr.strb[0]) begin
            nxt_status = status_ff & ~wr.data[3:0];
        end
        nxt_status = nxt_status | zero_evt;
        nxt_tmr_irq = nxt_status & nxt_ien;
        nxt_irq = |nxt_tmr_irq;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            status_ff <= 4'h0;
            ien_ff <= 4'h0;
            tmr_irq_ff <= 4'h0;
            irq_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            ien_ff <= nxt_ien;
            tmr_irq_ff <= nxt_tmr_irq;
            irq_ff <= nxt_irq;
        end
    end

    assign tmr_irq_o = tmr_irq_ff;
    assign irq_o = irq_ff;

    AST_STICKY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        status_ff[0] && !(clr_wr && wr.strb[0] && wr.data[0]) |=>
        status_ff[0])
        else $error("interrupt flag fell without a clear");
    AST_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        clr_wr && wr.strb[0] && wr.data[1] && !zero_evt[1] |=>
        !status_ff[1])
        else $error("clear write left the flag set");
    AST_IRQ_OUT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_o == |(status_ff & ien_ff))
        else $error("interrupt output disagrees with status and enable");
    AST_TMR_IRQ: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        tmr_irq_o == (status_ff & ien_ff))
        else $error("per timer interrupt disagrees with status");
    // A zero event must land even when software clears in that cycle
    AST_SET_WINS: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        zero_evt[0] |=> status_ff[0])
        else $error("zero event was lost");
    AST_WR_ONCE: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        wr_en |=> !wr_en)
        else $error("one bus write applied twice");
    AST_BHOLD: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was taken");
    AST_RHOLD: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before it was taken");

    ////////////////////////////////////////////////////////////////////////
    // Read decode

    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        if (rd_addr[7:6] == 2'h0) begin
            case (rd_addr[3:0])
                `QT_OFS_LOAD: rd_data = load_ff[rd_addr[5:4]];
                `QT_OFS_VALUE: rd_data = cnt[rd_addr[5:4]];
                `QT_OFS_CTRL: rd_data = {28'h0, ctrl_ff[rd_addr[5:4]]};
                default: rd_err = 1'b1;
            endcase
        end else begin
            case (rd_addr)
                `QT_OFS_IRQ_STATUS: rd_data = {28'h0, status_ff};
                `QT_OFS_IRQ_CLEAR: rd_data = 32'h00000000;
                `QT_OFS_IRQ_ENABLE: rd_data = {28'h0, ien_ff};
                default: rd_err = 1'b1;
            endcase
        end
    end

    AST_READ_LIVE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == `QT_OFS_VALUE |=>
        s_axi_rvalid && s_axi_rdata == $past(cnt[0]))
        else $error("value read did not return the live count");

endmodule
`default_nettype wire

// >>> sim/quad_downcount_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "qtimer_map.svh"

module quad_downcount_timer_tb;
    localparam logic [7:0] o_ld = `QT_OFS_LOAD;
    localparam logic [7:0] o_val = `QT_OFS_VALUE;
    localparam logic [7:0] o_ctl = `QT_OFS_CTRL;
    localparam logic [7:0] o_sts = `QT_OFS_IRQ_STATUS;
    localparam logic [7:0] o_clr = `QT_OFS_IRQ_CLEAR;
    localparam logic [7:0] o_ena = `QT_OFS_IRQ_ENABLE;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] aw_a = 8'h00;
    logic [7:0] ar_a = 8'h00;
    logic [31:0] w_d = 32'h0;
    logic [3:0] w_s = 4'h0;
    logic aw_v = 1'b0;
    logic w_v = 1'b0;
    logic b_r = 1'b0;
    logic ar_v = 1'b0;
    logic r_r = 1'b0;
    logic aw_r, w_r, b_v, ar_r, r_v, irq_a;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_d;
    logic [3:0] irq_v;
    int mismatches = 0;
    int total_checks = 0;
    int cyc = 0;
    int rd_at = 0;

    quad_downcount_timer i_quad_downcount_timer (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
        .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v),
        .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
        .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .tmr_irq_o(irq_v), .irq_o(irq_a)
    );

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic bail();
        mismatches++;
        $display("[FAIL] %0t wait ran out", $time);
        conclude();
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string m);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: %h vs %h", $time, m, seen, exp);
        end
    endtask

    function automatic logic [7:0] ad(input int t, input logic [7:0] o);
        return 8'(t) * `QT_TMR_STRIDE + o;
    endfunction

    function automatic logic [31:0] cv(input logic [1:0] p,
                                       input logic per, input logic en);
        return {28'h0, p, per, en};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Address and data go out together; each drops once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        aw_a <= a;
        w_d <= d;
        w_s <= 4'hf;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (aw_v && aw_r) aw_v <= 1'b0;
            if (w_v && w_r) w_v <= 1'b0;
            if (n > 200) bail();
        end while (b_v !== 1'b1);
        r = b_resp;
        b_r <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (ar_v && ar_r) begin
                ar_v <= 1'b0;
                rd_at = cyc;
            end
            if (n > 200) bail();
        end while (r_v !== 1'b1);
        d = r_d;
        r = r_resp;
        r_r <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_irq(input int t, output int at);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 5000) bail();
        end while (irq_v[t] !== 1'b1);
        at = cyc;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d, l, v1, v2;
        logic [31:0] ld [4];
        logic [1:0] r;
        int t, a1, a2, c1, sh;
        void'($urandom(32'h8f2bbaee));
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk(irq_a, 0, "irq after reset");
        for (t = 0; t < 4; t++) begin
            rd(ad(t, o_val), d, r);
            chk(d, `QT_CNT_RST, "reset count");
            rd(ad(t, o_ctl), d, r);
            chk(d, 0, "reset ctrl");
            rd(ad(t, o_ld), d, r);
            chk(d, `QT_LOAD_RST, "reset load");
        end
        rd(8'h3c, d, r);
        chk(r, `QT_RESP_SLVERR, "unmapped resp");
        chk(d, 0, "unmapped data");
        wr(ad(1, o_val), 32'h5, r);
        chk(r, `QT_RESP_SLVERR, "count write resp");
        rd(ad(1, o_val), d, r);
        chk(d, `QT_CNT_RST, "count not written");
        $display("test reset done");

        // Loads while disabled: value restarts, then holds
        for (t = 0; t < 4; t++) begin
            ld[t] = (t == 0) ? 32'hffffffff : $urandom;
            wr(ad(t, o_ld), ld[t], r);
            chk(r, `QT_RESP_OKAY, "load resp");
            rd(ad(t, o_val), d, r);
            chk(d, ld[t], "restart value");
        end
        repeat (40) @(posedge clk_i);
        for (t = 0; t < 4; t++) begin
            rd(ad(t, o_val), d, r);
            chk(d, ld[t], "disabled hold");
        end
        $display("test load done");

        // Tick rate for prescale codes 0 to 2; timer 3 must stay untouched
        for (t = 0; t < 3; t++) begin
            sh = t * 4;
            wr(ad(t, o_ld), 32'h00100000, r);
            wr(ad(t, o_ctl), cv(2'(t), 1'b0, 1'b1), r);
            rd(ad(t, o_val), v1, r);
            c1 = rd_at;
            repeat (600 + $urandom_range(99)) @(posedge clk_i);
            rd(ad(t, o_val), v2, r);
            l = 32'((rd_at - c1) >> sh);
            chk(32'(v1 - v2 + 1 >= l && v1 - v2 <= l + 1), 1, "rate");
            wr(ad(t, o_ctl), cv(2'(t), 1'b0, 1'b0), r);
            rd(ad(t, o_val), v1, r);
            repeat (300) @(posedge clk_i);
            rd(ad(t, o_val), v2, r);
            chk(v2, v1, "stopped hold");
            rd(ad(3, o_val), d, r);
            chk(d, ld[3], "other timer");
        end
        $display("test rate done");

        // Free-running wrap with sticky interrupt
        t = $urandom_range(3);
        l = 32'($urandom_range(40, 10));
        wr(o_ena, 32'(1 << t), r);
        rd(o_ena, d, r);
        chk(d, 32'(1 << t), "enable readback");
        wr(ad(t, o_ld), l, r);
        wr(ad(t, o_ctl), cv(2'h0, 1'b0, 1'b1), r);
        wait_irq(t, a1);
        repeat (30) @(posedge clk_i);
        chk(irq_v, 4'(1 << t), "level held");
        chk(irq_a, 1, "combined irq");
        rd(ad(t, o_val), d, r);
        chk(32'(d > 32'hffffff00), 1, "wrapped");
        rd(o_sts, d, r);
        chk(d, 32'(1 << t), "status set");
        wr(o_clr, 32'(1 << t), r);
        rd(o_sts, d, r);
        chk(d, 0, "status cleared");
        chk(irq_a, 0, "irq cleared");
        $display("test free done");

        // Periodic: repeated events exactly one period apart
        l = 32'($urandom_range(60, 30));
        wr(ad(t, o_ld), l, r);
        wr(ad(t, o_ctl), cv(2'h0, 1'b1, 1'b1), r);
        wait_irq(t, a1);
        wr(o_clr, 32'(1 << t), r);
        wait_irq(t, a2);
        chk(32'(a2 - a1), l + 1, "period");
        rd(ad(t, o_val), d, r);
        chk(32'(d <= l), 1, "reload bound");
        wr(o_ena, 32'h0, r);
        repeat (2 * l + 4) @(posedge clk_i);
        rd(o_sts, d, r);
        chk(d, 32'(1 << t), "status under mask");
        chk(irq_v, 0, "masked");
        chk(irq_a, 0, "masked combined");
        $display("test periodic done");

        // Load write while running restarts the count
        wr(ad(t, o_ctl), cv(2'h0, 1'b0, 1'b1), r);
        repeat (50) @(posedge clk_i);
        v1 = 32'h8000 | 32'($urandom_range(4095));
        wr(ad(t, o_ld), v1, r);
        rd(ad(t, o_val), d, r);
        chk(32'(d <= v1 && v1 - d <= 10), 1, "running restart");
        $display("test restart done");
        conclude();
    end
endmodule

`default_nettype wire
